/* File: logic/dfc_channel_ctrl.sv */
// Per-channel control of the decimating FIR stage: registers, shadowing,
// input selection, output formatting and the self-test signature engine.
// Assumes the microport decodes this channel and that all inputs share core_clk.
//
// Contract
// - Phase latched at every filter start
// - Sync keeps programmed phase, no reset
// - Pointer selects region of coefficient store
// - Pointer shadowed, applied at next filter
// - Control register is eleven bits wide
// - Bypass routes comb output to signatures
// - Control bit 9 selects own/other input
// - Other source: 0<-1, 1<-0, 2<-1, 3<-1
// - Bit 8 is coefficient write bank bit
// - Float: separate or shared exponent
// - Force scale in float, clip mantissas
// - Bits 5:4 select output format
// - Bits 3:0 hold output scale factor
// - I signature or mapped I data
// - Q signature or mapped Q data
// - Signatures stop after programmed output count
// - Writing a nonzero count register starts self-test
// - Map bit chooses signature or data mode
`timescale 1ns/10ps
module dfc_channel_ctrl import dfc_pkg::*; #(
	parameter int          CW      = 20,
	parameter int          DW      = 24,
	parameter logic [1:0]  CHAN_ID = 2'h0
) (
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire logic                reg_wr_en,
	input  wire logic                reg_rd_en,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [ST_CNT_W-1:0] reg_wdata,
	output logic      [ST_CNT_W-1:0] reg_rdata_r,
	input  wire logic                readback_map,
	input  wire logic                chan_sync,
	input  wire logic                fir_start,
	input  wire logic [4*CW-1:0]     comb_i_all,
	input  wire logic [4*CW-1:0]     comb_q_all,
	input  wire logic [3:0]          comb_valid_all,
	input  wire logic                fir_res_valid,
	input  wire logic [DW-1:0]       fir_res_i,
	input  wire logic [DW-1:0]       fir_res_q,
	output logic                     fir_in_valid_r,
	output logic      [CW-1:0]       fir_in_i_r,
	output logic      [CW-1:0]       fir_in_q_r,
	output logic      [7:0]          act_phase_r,
	output logic      [7:0]          act_taps_r,
	output logic      [7:0]          act_coef_ptr_r,
	output logic                     coef_wr_en_r,
	output logic      [7:0]          coef_wr_addr_r,
	output logic      [ST_CNT_W-1:0] coef_wr_data_r,
	output logic                     out_valid_r,
	output logic      [SIG_W-1:0]    out_i_r,
	output logic      [SIG_W-1:0]    out_q_r,
	output logic                     selftest_busy_r
);
	function automatic logic [1:0] src_chan(input logic other);
		if (!other) begin
			return CHAN_ID;
		end
		return (CHAN_ID == 2'h1) ? 2'h0 : 2'h1;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	logic [7:0]          phase_r;
	logic [7:0]          taps_r;
	logic [7:0]          coef_ptr_r;
	logic [CTRL_W-1:0]   ctrl_r;
	logic [ST_CNT_W-1:0] st_cnt_r;
	logic [SIG_W-1:0]    sig_i_r;
	logic [SIG_W-1:0]    sig_q_r;
	dfc_st_state_t       st_state_r;
	logic [1:0]          src;
	logic [SIG_W-1:0]    fmt_i;
	logic [SIG_W-1:0]    fmt_q;
	logic                st_load;

	assign src     = src_chan(ctrl_r[CTL_SRC]);
	assign st_load = reg_wr_en && hit(reg_addr, ADDR_ST_CNT);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_r    <= PHASE_RST;
			taps_r     <= TAPS_RST;
			coef_ptr_r <= PTR_RST;
			ctrl_r     <= CTRL_RST;
		end else if (reg_wr_en) begin
			if (hit(reg_addr, ADDR_PHASE)) begin
				phase_r <= reg_wdata[7:0];
			end
			if (hit(reg_addr, ADDR_TAPS)) begin
				taps_r <= reg_wdata[7:0];
			end
			if (hit(reg_addr, ADDR_COEF_PTR)) begin
				coef_ptr_r <= reg_wdata[7:0];
			end
			if (hit(reg_addr, ADDR_CTRL)) begin
				ctrl_r <= reg_wdata[CTRL_W-1:0];
			end
		end
	end

	// Working copies change only when a computation begins, the phase also at a channel sync, so a host write
	// in mid-filter never mixes two settings within one output sample.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			act_phase_r    <= PHASE_RST;
			act_taps_r     <= TAPS_RST;
			act_coef_ptr_r <= PTR_RST;
		end else begin
			if (fir_start || chan_sync) begin
				act_phase_r <= phase_r;
			end
			if (fir_start) begin
				act_taps_r     <= taps_r;
				act_coef_ptr_r <= coef_ptr_r;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			coef_wr_en_r   <= 1'b0;
			coef_wr_addr_r <= 8'h00;
			coef_wr_data_r <= CNT_RST;
		end else begin
			coef_wr_en_r <= reg_wr_en && reg_addr <= COEF_ADDR_MAX;
			if (reg_wr_en && reg_addr <= COEF_ADDR_MAX) begin
				coef_wr_addr_r <= {ctrl_r[CTL_BANK], reg_addr[6:0]};
				coef_wr_data_r <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			fir_in_valid_r <= 1'b0;
			fir_in_i_r     <= '0;
			fir_in_q_r     <= '0;
		end else begin
			fir_in_valid_r <= comb_valid_all[src];
			fir_in_i_r     <= comb_i_all[src*CW +: CW];
			fir_in_q_r     <= comb_q_all[src*CW +: CW];
		end
	end

	dfc_formatter #(
		.DW(DW)
	) u_fmt (
		.res_i      (fir_res_i),
		.res_q      (fir_res_q),
		.fmt        (ctrl_r[CTL_FMT_HI:CTL_FMT_LO]),
		.common_exp (ctrl_r[CTL_COMEXP]),
		.force_scale(ctrl_r[CTL_FORCE]),
		.scale      (ctrl_r[CTL_SCL_HI:0]),
		.fmt_i      (fmt_i),
		.fmt_q      (fmt_q)
	);

	// In bypass the filter result is ignored and comb samples feed the signatures.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			out_valid_r <= 1'b0;
			out_i_r     <= SIG_RST;
			out_q_r     <= SIG_RST;
		end else if (ctrl_r[CTL_BYPASS]) begin
			out_valid_r <= comb_valid_all[src];
			out_i_r     <= comb_i_all[src*CW+CW-SIG_W +: SIG_W];
			out_q_r     <= comb_q_all[src*CW+CW-SIG_W +: SIG_W];
		end else begin
			out_valid_r <= fir_res_valid;
			out_i_r     <= fmt_i;
			out_q_r     <= fmt_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_state_r <= DFC_ST_IDLE;
			st_cnt_r   <= CNT_RST;
		end else if (st_load) begin
			st_cnt_r   <= reg_wdata;
			st_state_r <= (reg_wdata == CNT_RST) ? DFC_ST_DONE : DFC_ST_RUN;
		end else begin
			unique case (st_state_r)
				DFC_ST_IDLE: begin
					st_state_r <= DFC_ST_IDLE;
				end
				DFC_ST_RUN: begin
					if (out_valid_r && !readback_map) begin
						st_cnt_r <= st_cnt_r - 20'h00001;
						if (st_cnt_r == 20'h00001) begin
							st_state_r <= DFC_ST_DONE;
						end
					end
				end
				DFC_ST_DONE: begin
					st_state_r <= DFC_ST_DONE;
				end
				default: begin
					st_state_r <= DFC_ST_IDLE;
				end
			endcase
		end
	end

	// A shift-and-fold signature; outside map mode a start clears it so runs are repeatable.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sig_i_r <= SIG_RST;
			sig_q_r <= SIG_RST;
		end else if (readback_map) begin
			if (out_valid_r) begin
				sig_i_r <= out_i_r;
				sig_q_r <= out_q_r;
			end
		end else if (st_load) begin
			sig_i_r <= SIG_RST;
			sig_q_r <= SIG_RST;
		end else if (st_state_r == DFC_ST_RUN && out_valid_r) begin
			sig_i_r <= ({sig_i_r[14:0], 1'b0} ^ (sig_i_r[15] ? SIG_POLY : SIG_RST)) ^ out_i_r;
			sig_q_r <= ({sig_q_r[14:0], 1'b0} ^ (sig_q_r[15] ? SIG_POLY : SIG_RST)) ^ out_q_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			selftest_busy_r <= 1'b0;
		end else begin
			selftest_busy_r <= st_load ? (reg_wdata != CNT_RST) :
				(st_state_r == DFC_ST_RUN && !(out_valid_r && !readback_map &&
				st_cnt_r == 20'h00001));
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata_r <= CNT_RST;
		end else if (reg_rd_en) begin
			unique case (reg_addr)
				ADDR_PHASE:    reg_rdata_r <= {12'h000, phase_r};
				ADDR_TAPS:     reg_rdata_r <= {12'h000, taps_r};
				ADDR_COEF_PTR: reg_rdata_r <= {12'h000, coef_ptr_r};
				ADDR_CTRL:     reg_rdata_r <= {9'h000, ctrl_r};
				ADDR_SIG_I:    reg_rdata_r <= {4'h0, sig_i_r};
				ADDR_SIG_Q:    reg_rdata_r <= {4'h0, sig_q_r};
				ADDR_ST_CNT:   reg_rdata_r <= st_cnt_r;
				default:       reg_rdata_r <= CNT_RST;
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_st_write;
		reg_wr_en && reg_addr == ADDR_ST_CNT && reg_wdata != CNT_RST && !readback_map;
	endsequence

	a_phase_at_start: assert property (fir_start |=> act_phase_r == $past(phase_r))
		else $error("Phase not taken at filter start.");
	a_phase_on_sync: assert property (chan_sync |=> act_phase_r == $past(phase_r))
		else $error("Sync did not keep programmed phase.");
	a_ptr_shadow: assert property (!fir_start |=> act_coef_ptr_r == $past(act_coef_ptr_r))
		else $error("Coefficient pointer moved outside a filter start.");
	a_taps_sample: assert property (fir_start |=> act_taps_r == $past(taps_r))
		else $error("Tap count not sampled at filter start.");
	a_ctrl_width: assert property (reg_rd_en && reg_addr == ADDR_CTRL
		|=> reg_rdata_r[ST_CNT_W-1:CTRL_W] == '0)
		else $error("Control readback wider than eleven bits.");
	a_bank_bit: assert property (reg_wr_en && reg_addr <= COEF_ADDR_MAX
		|=> coef_wr_en_r && coef_wr_addr_r[7] == $past(ctrl_r[CTL_BANK]))
		else $error("Coefficient bank bit not applied.");
	a_own_source: assert property (!ctrl_r[CTL_SRC] && comb_valid_all[CHAN_ID]
		|=> fir_in_valid_r && fir_in_i_r == $past(comb_i_all[CHAN_ID*CW +: CW]))
		else $error("Own comb data not selected.");
	// Channel 1 borrows from channel 0; every other channel borrows from channel 1.
	a_other_source: assert property (ctrl_r[CTL_SRC] && comb_valid_all[src]
		|=> fir_in_valid_r
		&& fir_in_i_r == $past(comb_i_all[((CHAN_ID == 2'h1) ? 0 : CW) +: CW]))
		else $error("Other channel comb data not selected.");
	a_coef_range: assert property (reg_wr_en && reg_addr > COEF_ADDR_MAX
		|=> !coef_wr_en_r)
		else $error("Coefficient write outside the coefficient address range.");
	a_map_data: assert property (readback_map && out_valid_r
		|=> sig_i_r == $past(out_i_r) && sig_q_r == $past(out_q_r))
		else $error("Mapped data not presented in signature registers.");
	a_start_run: assert property (s_st_write
		|=> st_state_r == DFC_ST_RUN && st_cnt_r == $past(reg_wdata) && sig_i_r == SIG_RST
		&& sig_q_r == SIG_RST)
		else $error("Self-test did not start on count write.");
	a_sig_stop: assert property (st_state_r == DFC_ST_DONE && !readback_map && !st_load
		|=> $stable(sig_i_r) && $stable(sig_q_r))
		else $error("Signature changed after programmed count.");
	a_bypass_route: assert property (ctrl_r[CTL_BYPASS] && !fir_res_valid
		&& !comb_valid_all[src] |=> !out_valid_r)
		else $error("Output valid in bypass without comb data.");
endmodule

/* File: logic/dfc_pkg.sv */
// Shared constants for the decimating FIR channel control block.
// Assumes an 8-bit channel address space reached through the microport.
package dfc_pkg;
	localparam logic [7:0] ADDR_PHASE    = 8'hA1;
	localparam logic [7:0] ADDR_TAPS     = 8'hA2;
	localparam logic [7:0] ADDR_COEF_PTR = 8'hA3;
	localparam logic [7:0] ADDR_CTRL     = 8'hA4;
	localparam logic [7:0] ADDR_SIG_I    = 8'hA5;
	localparam logic [7:0] ADDR_SIG_Q    = 8'hA6;
	localparam logic [7:0] ADDR_ST_CNT   = 8'hA7;
	localparam logic [7:0] COEF_ADDR_MAX = 8'h7F;

	localparam int CTRL_W      = 11;
	localparam int CTL_BYPASS  = 10;
	localparam int CTL_SRC     = 9;
	localparam int CTL_BANK    = 8;
	localparam int CTL_COMEXP  = 7;
	localparam int CTL_FORCE   = 6;
	localparam int CTL_FMT_HI  = 5;
	localparam int CTL_FMT_LO  = 4;
	localparam int CTL_SCL_HI  = 3;
	localparam int ST_CNT_W    = 20;
	localparam int SIG_W       = 16;
	localparam int COEF_WORDS  = 256;

	localparam logic [7:0]          PHASE_RST = 8'h00;
	localparam logic [7:0]          TAPS_RST  = 8'h00;
	localparam logic [7:0]          PTR_RST   = 8'h00;
	localparam logic [CTRL_W-1:0]   CTRL_RST  = 11'h000;
	localparam logic [ST_CNT_W-1:0] CNT_RST   = 20'h00000;
	localparam logic [SIG_W-1:0]    SIG_RST   = 16'h0000;
	localparam logic [SIG_W-1:0]    SIG_POLY  = 16'h8016;

	localparam logic [1:0] FMT_FIXED = 2'h0;
	localparam logic [1:0] FMT_F8    = 2'h1;

	typedef enum logic [1:0] {
		DFC_ST_IDLE = 2'b00,
		DFC_ST_RUN  = 2'b01,
		DFC_ST_DONE = 2'b11
	} dfc_st_state_t;
endpackage

/* File: logic/dfc_formatter.sv */
// Output formatter for the filter result: fixed point or block floating point.
// Assumes signed results of width DW, at least 24 bits.
`timescale 1ns/10ps
module dfc_formatter import dfc_pkg::*; #(
	parameter int DW = 24
) (
	input  wire logic [DW-1:0]    res_i,
	input  wire logic [DW-1:0]    res_q,
	input  wire logic [1:0]       fmt,
	input  wire logic             common_exp,
	input  wire logic             force_scale,
	input  wire logic [3:0]       scale,
	output logic      [SIG_W-1:0] fmt_i,
	output logic      [SIG_W-1:0] fmt_q
);
	function automatic logic [3:0] lead_cnt(input logic [DW-1:0] x);
		logic [3:0] n;
		logic       run;
		n = 4'h0;
		run = 1'b1;
		for (int k = DW - 2; k >= 0; k--) begin
			if (run && x[k] == x[DW-1] && n != 4'hF) begin
				n = n + 4'h1;
			end else begin
				run = 1'b0;
			end
		end
		return n;
	endfunction

	// Clips instead of wrapping so an oversized value keeps its sign.
	function automatic logic [DW-1:0] sat_shift(input logic [DW-1:0] x, input logic [3:0] s);
		logic [DW+15:0] w;
		w = {{16{x[DW-1]}}, x} <<< s;
		if (w[DW+15:DW-1] == '0 || w[DW+15:DW-1] == '1) begin
			return w[DW-1:0];
		end else begin
			return x[DW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
		end
	endfunction

	function automatic logic [SIG_W-1:0] pack(input logic [DW-1:0] n, input logic [3:0] e,
		input logic [1:0] f);
		if (f[1]) begin
			return {n[DW-1:DW-12], e};
		end else begin
			return {4'h0, n[DW-1:DW-8], e};
		end
	endfunction

	logic [3:0]    li;
	logic [3:0]    lq;
	logic [3:0]    ei;
	logic [3:0]    eq;
	logic [DW-1:0] si;
	logic [DW-1:0] sq;

	always_comb begin
		li = lead_cnt(res_i);
		lq = lead_cnt(res_q);
		si = sat_shift(res_i, scale);
		sq = sat_shift(res_q, scale);
		ei = li;
		eq = lq;
		if (common_exp) begin
			ei = (li < lq) ? li : lq;
			eq = ei;
		end
		if (fmt == FMT_FIXED) begin
			fmt_i = si[DW-1:DW-SIG_W];
			fmt_q = sq[DW-1:DW-SIG_W];
		end else if (force_scale) begin
			fmt_i = pack(si, scale, fmt);
			fmt_q = pack(sq, scale, fmt);
		end else begin
			fmt_i = pack(res_i <<< ei, ei, fmt);
			fmt_q = pack(res_q <<< eq, eq, fmt);
		end
	end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the decimating FIR channel control block, channel 0.
// Assumes one 250 MHz clock and a host that drives the register strobes directly.
`timescale 1ns/10ps
module tb_top import dfc_pkg::*;;
	logic                core_clk;
	logic                srst;
	logic                reg_wr_en;
	logic                reg_rd_en;
	logic [7:0]          reg_addr;
	logic [ST_CNT_W-1:0] reg_wdata;
	logic [ST_CNT_W-1:0] reg_rdata_r;
	logic                readback_map;
	logic                chan_sync;
	logic                fir_start;
	logic [79:0]         comb_i_all;
	logic [79:0]         comb_q_all;
	logic [3:0]          comb_valid_all;
	logic                fir_res_valid;
	logic [23:0]         fir_res_i;
	logic [23:0]         fir_res_q;
	logic                fir_in_valid_r;
	logic [19:0]         fir_in_i_r;
	logic [19:0]         fir_in_q_r;
	logic [7:0]          act_phase_r;
	logic [7:0]          act_taps_r;
	logic [7:0]          act_coef_ptr_r;
	logic                coef_wr_en_r;
	logic [7:0]          coef_wr_addr_r;
	logic [ST_CNT_W-1:0] coef_wr_data_r;
	logic                out_valid_r;
	logic [SIG_W-1:0]    out_i_r;
	logic [SIG_W-1:0]    out_q_r;
	logic                selftest_busy_r;
	int                  fail_count;
	int                  checks_done;

	dfc_channel_ctrl #(.CW(20), .DW(24), .CHAN_ID(2'h0)) DUT (
		.core_clk(core_clk), .srst(srst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
		.readback_map(readback_map), .chan_sync(chan_sync), .fir_start(fir_start),
		.comb_i_all(comb_i_all), .comb_q_all(comb_q_all), .comb_valid_all(comb_valid_all),
		.fir_res_valid(fir_res_valid), .fir_res_i(fir_res_i), .fir_res_q(fir_res_q),
		.fir_in_valid_r(fir_in_valid_r), .fir_in_i_r(fir_in_i_r), .fir_in_q_r(fir_in_q_r),
		.act_phase_r(act_phase_r), .act_taps_r(act_taps_r), .act_coef_ptr_r(act_coef_ptr_r),
		.coef_wr_en_r(coef_wr_en_r), .coef_wr_addr_r(coef_wr_addr_r),
		.coef_wr_data_r(coef_wr_data_r), .out_valid_r(out_valid_r), .out_i_r(out_i_r),
		.out_q_r(out_q_r), .selftest_busy_r(selftest_busy_r)
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [19:0] d);
		@(posedge core_clk);
		reg_wr_en <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, input logic [19:0] exp, input string msg);
		@(posedge core_clk);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		#1;
		check(reg_rdata_r === exp, msg);
	endtask

	// One-cycle pulse: 0 filter start, 1 channel sync, 2 filter result valid.
	// Returns just after the edge that samples it.
	task automatic pulse(input int sel);
		@(posedge core_clk);
		fir_start     <= (sel == 0);
		chan_sync     <= (sel == 1);
		fir_res_valid <= (sel == 2);
		@(posedge core_clk);
		fir_start     <= 1'b0;
		chan_sync     <= 1'b0;
		fir_res_valid <= 1'b0;
		#1;
	endtask

	// Width of the control word and unmapped reads.
	task automatic t_regs();
		wr(ADDR_CTRL, 20'hFFFFF);
		rd(ADDR_CTRL, 20'h007FF, "control word width");
		wr(ADDR_CTRL, 20'h00000);
		rd(8'hB3, 20'h00000, "unmapped read not zero");
	endtask

	// Working copies move only at a filter start; sync restores the programmed phase.
	task automatic t_shadow();
		wr(ADDR_PHASE, 20'h00005);
		wr(ADDR_TAPS, 20'h0001F);
		wr(ADDR_COEF_PTR, 20'h00040);
		#1;
		check(act_coef_ptr_r === 8'h00, "pointer moved before start");
		check(act_taps_r === 8'h00, "taps moved before start");
		rd(ADDR_TAPS, 20'h0001F, "taps readback");
		pulse(0);
		@(posedge core_clk);
		#1;
		check(act_phase_r === 8'h05, "phase not taken at start");
		check(act_coef_ptr_r === 8'h40, "pointer not taken at start");
		check(act_taps_r === 8'h1F, "taps not taken at start");
		wr(ADDR_PHASE, 20'h00002);
		#1;
		check(act_phase_r === 8'h05, "phase moved before start");
		pulse(1);
		@(posedge core_clk);
		#1;
		check(act_phase_r === 8'h02, "sync lost programmed phase");
	endtask

	// Own source, then the other source, which is channel 1 for channel 0.
	task automatic t_source();
		comb_i_all <= {20'h44444, 20'h33333, 20'h22222, 20'h11111};
		comb_q_all <= {20'hDDDDD, 20'hCCCCC, 20'hBBBBB, 20'hAAAAA};
		comb_valid_all <= 4'hF;
		@(posedge core_clk);
		@(posedge core_clk);
		#1;
		check(fir_in_i_r === 20'h11111 && fir_in_valid_r === 1'b1, "own source");
		wr(ADDR_CTRL, 20'h00200);
		@(posedge core_clk);
		#1;
		check(fir_in_i_r === 20'h22222 && fir_in_q_r === 20'hBBBBB, "other source");
		comb_valid_all <= 4'h0;
	endtask

	// Bank bit extends coefficient write addresses; then the bypass path.
	task automatic t_coef_bypass();
		wr(ADDR_CTRL, 20'h00100);
		wr(8'h05, 20'h12345);
		#1;
		check(coef_wr_en_r === 1'b1 && coef_wr_addr_r === 8'h85, "bank address");
		check(coef_wr_data_r === 20'h12345, "coefficient data");
		readback_map <= 1'b1;
		wr(ADDR_CTRL, 20'h00400);
		comb_valid_all <= 4'h1;
		@(posedge core_clk);
		comb_valid_all <= 4'h0;
		repeat (3) @(posedge core_clk);
		rd(ADDR_SIG_I, 20'h01111, "bypass I readback");
		rd(ADDR_SIG_Q, 20'h0AAAA, "bypass Q readback");
	endtask

	// Fixed point with scale, including saturation at the top of the range.
	task automatic t_fixed();
		wr(ADDR_CTRL, 20'h00001);
		fir_res_i <= 24'h123456;
		fir_res_q <= 24'h400000;
		pulse(2);
		check(out_valid_r === 1'b1 && out_i_r === 16'h2468, "fixed scaled I");
		check(out_q_r === 16'h7FFF, "fixed saturated Q");
		@(posedge core_clk);
		rd(ADDR_SIG_I, 20'h02468, "mapped I readback");
	endtask

	// Self-test counts two outputs then freezes the signatures.
	task automatic t_selftest();
		readback_map <= 1'b0;
		wr(ADDR_CTRL, 20'h00000);
		wr(ADDR_ST_CNT, 20'h00002);
		#1;
		check(selftest_busy_r === 1'b1, "write did not start");
		pulse(2);
		fir_res_i <= 24'h0F0F00;
		pulse(2);
		@(posedge core_clk);
		#1;
		check(selftest_busy_r === 1'b0, "count not ended");
		rd(ADDR_ST_CNT, 20'h00000, "remaining count");
		// Two folds from a cleared signature: I sees 1234 then 0F0F, Q sees 4000 twice.
		rd(ADDR_SIG_I, 20'h02B67, "I signature");
		rd(ADDR_SIG_Q, 20'h0C000, "Q signature");
		pulse(2);
		rd(ADDR_SIG_I, 20'h02B67, "signature kept folding");
	endtask

	// Floating formats with own and shared exponents, then forced scale with clipping.
	task automatic t_float();
		wr(ADDR_CTRL, 20'h00020);
		fir_res_i <= 24'h123456;
		fir_res_q <= 24'h400000;
		pulse(2);
		check(out_i_r === 16'h48D2 && out_q_r === 16'h4000, "twelve plus four");
		wr(ADDR_CTRL, 20'h000A0);
		pulse(2);
		check(out_i_r === 16'h1230 && out_q_r === 16'h4000, "shared exponent");
		wr(ADDR_CTRL, 20'h00010);
		pulse(2);
		check(out_i_r === 16'h0482, "eight plus four");
		wr(ADDR_CTRL, 20'h00061);
		pulse(2);
		check(out_i_r === 16'h2461 && out_q_r === 16'h7FF1, "forced scale clip");
	endtask

	initial begin
		fail_count = 0;
		checks_done = 0;
		srst = 1'b1;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 20'h00000;
		readback_map = 1'b0;
		chan_sync = 1'b0;
		fir_start = 1'b0;
		comb_i_all = '0;
		comb_q_all = '0;
		comb_valid_all = 4'h0;
		fir_res_valid = 1'b0;
		fir_res_i = 24'h000000;
		fir_res_q = 24'h000000;
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		t_regs();
		t_shadow();
		t_source();
		t_coef_bypass();
		t_fixed();
		t_selftest();
		t_float();
		stop_test();
	end

	// The whole sequence needs well under a thousand cycles.
	initial begin
		#20000;
		fail_count++;
		stop_test();
	end
endmodule
